/* File: rtl/ocfrs_sequencer.sv */
/*
 Overcurrent fault-response sequencer: response setting register, latched
 fault flag, limit/shutdown decision and bounded or unbounded restarts.
 Assumes overcurrent and low-voltage comparators, the on/off command and the
 status-clear strobe are synchronous to sys_clk; the analog loop is outside.
*/
// Operation
// - Response 00 limits current forever, never shuts down for overcurrent.
// - Response 01 limits while voltage above floor, else shuts down and follows retry setting; in a restart attempt the code shuts down at once.
// - Response 10 limits for delay units, then shuts down if still limiting; in a restart attempt the code shuts down at once.
// - Response 11 shuts down immediately then follows retry setting.
// - Retry 000 means no restart; output stays off until cleared.
// - Retry 001 to 110 allows that many restart attempts.
// - Attempts exhausted without success leaves output latched off.
// - Restart attempts start spaced by delay count times delay unit.
// - Retry 111 restarts forever until commanded off or another fault.
// - Delay field is a unit count for run-on or restart spacing.
// - Fault flag sets on detection for every response value.
// - Fault flag stays latched until the status-clear action.
// - Host notify pulses whenever the fault flag gets set.
// - Latched off holds until reset, off-then-on command, or power loss.
`timescale 1ns/1ns
`include "ocfrs_consts.svh"
module ocfrs_sequencer
    import ocfrs_pkg::*;
#(
    parameter int UNIT_CYCLES = `OCFRS_UNIT_CYCLES,
    parameter int RESTART_CYCLES = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Response setting register port
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] overcurrent_response_setting,
    // Analog monitor inputs
    input wire logic oc_detect,
    input wire logic below_lv_floor,
    input wire logic other_fault,
    // Output on/off command (pin and command combined)
    input wire logic output_on_cmd,
    // Status clearing
    input wire logic status_clear,
    // Power stage control and status
    output logic output_enable,
    output logic current_limit_active,
    output logic oc_fault_flag,
    output logic host_notify,
    output logic latched_off,
    output logic [2:0] retries_left
);
    initial begin
        if (RESTART_CYCLES < 1) begin
            $error("RESTART_CYCLES must be at least one");
        end
    end

    localparam int RW = $clog2(RESTART_CYCLES + 1);

    ocfrs_state_e state_r, state_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic flag_r, flag_nxt;
    logic notify_r, notify_nxt;
    logic [2:0] retry_r, retry_nxt;
    logic [RW-1:0] rst_cnt_r, rst_cnt_nxt;
    logic on_prev_r;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;
    logic [2:0] retry_fld;
    logic [2:0] delay_fld;
    ocfrs_act_e act;
    logic shut_now;
    logic retry_ok;
    logic [2:0] reload;
    logic [2:0] budget;

    assign act = ocfrs_act_e'(cfg_r[`OCFRS_ACT_HI:`OCFRS_ACT_LO]);
    assign retry_fld = cfg_r[`OCFRS_RETRY_HI:`OCFRS_RETRY_LO];
    assign delay_fld = cfg_r[`OCFRS_DELAY_HI:`OCFRS_DELAY_LO];

    // Run-on and retry spacing share one timer; never needed at once
    ocfrs_delay_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(tmr_start),
        .units(delay_fld),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // Full budget of the current setting, capped at the largest bounded count
    assign reload = (retry_fld > `OCFRS_RETRY_MAX) ? `OCFRS_RETRY_MAX : retry_fld;
    // Before the first shutdown the setting decides; retry_r lags a fresh write by a cycle
    assign budget = (state_r == OCFRS_ST_RUN || state_r == OCFRS_ST_LIMIT) ? reload : retry_r;

    // Retry permission: unbounded, or attempts remain
    assign retry_ok = (retry_fld == `OCFRS_RETRY_FOREVER) || (budget != 3'h0);

    // Register and flag next values
    always_comb begin
        cfg_nxt = cfg_r;
        if (cfg_wr) begin
            cfg_nxt = cfg_wdata;
        end
        flag_nxt = flag_r;
        notify_nxt = 1'b0;
        if (status_clear) begin
            flag_nxt = 1'b0;
        end
        // Detection wins over a clear in the same cycle
        if (oc_detect) begin
            flag_nxt = 1'b1;
            notify_nxt = !flag_r;
        end
    end

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        retry_nxt = retry_r;
        rst_cnt_nxt = rst_cnt_r;
        tmr_start = 1'b0;
        shut_now = 1'b0;
        case (state_r)
            OCFRS_ST_RUN: begin
                // Fresh episode gets the full budget
                retry_nxt = (retry_fld > `OCFRS_RETRY_MAX) ? `OCFRS_RETRY_MAX : retry_fld;
                if (oc_detect) begin
                    case (act)
                        OCFRS_ACT_LIMIT: state_nxt = OCFRS_ST_LIMIT;
                        OCFRS_ACT_LV_FLOOR: state_nxt = OCFRS_ST_LIMIT;
                        OCFRS_ACT_DELAYED: begin
                            state_nxt = OCFRS_ST_LIMIT;
                            tmr_start = 1'b1;
                        end
                        default: shut_now = 1'b1;
                    endcase
                end
            end
            OCFRS_ST_LIMIT: begin
                if (!oc_detect) begin
                    state_nxt = OCFRS_ST_RUN;
                end else if (act == OCFRS_ACT_LV_FLOOR && below_lv_floor) begin
                    shut_now = 1'b1;
                end else if (act == OCFRS_ACT_DELAYED && tmr_done) begin
                    shut_now = 1'b1;
                end else if (act == OCFRS_ACT_IMMEDIATE) begin
                    shut_now = 1'b1;
                end
            end
            OCFRS_ST_WAIT: begin
                // Spacing measured from the start of the previous attempt; an idle
                // timer has already expired (late fault in RESTART, or zero delay)
                if (tmr_done || !tmr_busy) begin
                    state_nxt = OCFRS_ST_RESTART;
                    rst_cnt_nxt = RW'(RESTART_CYCLES);
                    tmr_start = 1'b1;
                end
            end
            OCFRS_ST_RESTART: begin
                if (oc_detect) begin
                    if (act == OCFRS_ACT_LIMIT) begin
                        state_nxt = OCFRS_ST_LIMIT;
                    end else begin
                        shut_now = 1'b1;
                    end
                end else if (rst_cnt_r <= RW'(1)) begin
                    state_nxt = OCFRS_ST_RUN;
                end else begin
                    rst_cnt_nxt = rst_cnt_r - 1'b1;
                end
            end
            OCFRS_ST_OFF, OCFRS_ST_LATCHED: begin
                state_nxt = state_r;
            end
            default: state_nxt = OCFRS_ST_LATCHED;
        endcase
        // Shutdown: retry or latch; retry 000 and an empty budget both latch
        if (shut_now) begin
            if (retry_ok) begin
                state_nxt = OCFRS_ST_WAIT;
                if (retry_fld != `OCFRS_RETRY_FOREVER) begin
                    retry_nxt = budget - 1'b1;
                end
                if (state_r != OCFRS_ST_RESTART) begin
                    tmr_start = 1'b1;
                end
            end else begin
                state_nxt = OCFRS_ST_LATCHED;
            end
        end
        // Another fault ends unbounded retrying
        if (other_fault && state_r == OCFRS_ST_WAIT) begin
            state_nxt = OCFRS_ST_LATCHED;
        end
        // Commanded off stops everything; on edge re-arms
        if (!output_on_cmd) begin
            state_nxt = OCFRS_ST_OFF;
        end else if (!on_prev_r && state_r == OCFRS_ST_OFF) begin
            state_nxt = OCFRS_ST_RUN;
            retry_nxt = (retry_fld > `OCFRS_RETRY_MAX) ? `OCFRS_RETRY_MAX : retry_fld;
        end
    end

    // Register stage; bias-power loss arrives as rst_n
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= OCFRS_ST_OFF;
            cfg_r <= `OCFRS_CFG_RESET;
            flag_r <= 1'b0;
            notify_r <= 1'b0;
            retry_r <= 3'h0;
            rst_cnt_r <= '0;
            on_prev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cfg_r <= cfg_nxt;
            flag_r <= flag_nxt;
            notify_r <= notify_nxt;
            retry_r <= retry_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            on_prev_r <= output_on_cmd;
        end
    end

    // Outputs, all from flip-flops
    assign overcurrent_response_setting = cfg_r;
    assign output_enable = (state_r == OCFRS_ST_RUN) || (state_r == OCFRS_ST_LIMIT) ||
        (state_r == OCFRS_ST_RESTART);
    assign current_limit_active = (state_r == OCFRS_ST_LIMIT);
    assign oc_fault_flag = flag_r;
    assign host_notify = notify_r;
    assign latched_off = (state_r == OCFRS_ST_LATCHED);
    assign retries_left = retry_r;
endmodule

/* File: rtl/ocfrs_consts.svh */
/*
 Named constants for the overcurrent fault-response sequencer:
 field positions of the response setting, encodings, reset values and timing.
 Assumes inclusion by the sequencer and delay timer modules only.
*/
`ifndef OCFRS_CONSTS_SVH
`define OCFRS_CONSTS_SVH

// Field layout of the one-byte response setting
`define OCFRS_ACT_HI 7
`define OCFRS_ACT_LO 6
`define OCFRS_RETRY_HI 5
`define OCFRS_RETRY_LO 3
`define OCFRS_DELAY_HI 2
`define OCFRS_DELAY_LO 0

// Retry field encodings
`define OCFRS_RETRY_NONE 3'h0
`define OCFRS_RETRY_MAX 3'h6
`define OCFRS_RETRY_FOREVER 3'h7

// Reset value of the response setting (immediate shutdown, no retry)
`define OCFRS_CFG_RESET 8'hc0

// Delay unit in microseconds and clock rate in MHz
`define OCFRS_UNIT_US 1000
`define OCFRS_CLK_MHZ 10
`define OCFRS_UNIT_CYCLES (`OCFRS_UNIT_US * `OCFRS_CLK_MHZ)

`endif

/* File: rtl/ocfrs_pkg.sv */
/*
 Types of the overcurrent fault-response sequencer.
 Assumes the constants header sits beside it in rtl/.
*/
package ocfrs_pkg;
    // Response action encodings (bits 7:6)
    typedef enum logic [1:0] {
        OCFRS_ACT_LIMIT = 2'h0,
        OCFRS_ACT_LV_FLOOR = 2'h1,
        OCFRS_ACT_DELAYED = 2'h2,
        OCFRS_ACT_IMMEDIATE = 2'h3
    } ocfrs_act_e;

    // Sequencer states, Gray coded along run, limit, off, wait, restart
    typedef enum logic [2:0] {
        OCFRS_ST_RUN = 3'h0,
        OCFRS_ST_LIMIT = 3'h1,
        OCFRS_ST_OFF = 3'h3,
        OCFRS_ST_WAIT = 3'h2,
        OCFRS_ST_RESTART = 3'h6,
        OCFRS_ST_LATCHED = 3'h7
    } ocfrs_state_e;
endpackage

/* File: rtl/ocfrs_delay_timer.sv */
/*
 Delay timer: counts a number of delay units, each a fixed cycle count.
 Assumes a one-cycle start pulse; start while busy restarts the count.
*/
`timescale 1ns/1ns
`include "ocfrs_consts.svh"
module ocfrs_delay_timer
    import ocfrs_pkg::*;
#(
    parameter int UNIT_CYCLES = `OCFRS_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [2:0] units,
    // Status
    output logic busy,
    output logic done
);
    initial begin
        if (UNIT_CYCLES < 1) begin
            $error("UNIT_CYCLES must be at least one");
        end
    end

    localparam int CW = $clog2(UNIT_CYCLES + 1);

    logic [CW-1:0] cyc_r, cyc_nxt;
    logic [2:0] unit_r, unit_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;

    // Next values: unit count down, then cycle count down within each unit
    always_comb begin
        cyc_nxt = cyc_r;
        unit_nxt = unit_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (start) begin
            cyc_nxt = CW'(UNIT_CYCLES - 1);
            unit_nxt = units;
            // A zero count expires at once
            busy_nxt = (units != 3'h0);
            done_nxt = (units == 3'h0);
        end else if (busy_r) begin
            if (cyc_r != '0) begin
                cyc_nxt = cyc_r - 1'b1;
            end else if (unit_r <= 3'h1) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                unit_nxt = unit_r - 1'b1;
                cyc_nxt = CW'(UNIT_CYCLES - 1);
            end
        end
    end

    // Register stage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cyc_r <= '0;
            unit_r <= 3'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cyc_r <= cyc_nxt;
            unit_r <= unit_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = busy_r;
    assign done = done_r;
endmodule

/* File: dv/ocfrs_sequencer_chk.sv */
/*
 Port checker for the fault sequencer.
 Assumes a bind onto ocfrs_sequencer; one clock domain.
*/
`timescale 1ns/1ns
module ocfrs_sequencer_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Inputs
    input wire logic cfg_wr,
    input wire logic oc_detect,
    input wire logic below_lv_floor,
    input wire logic other_fault,
    input wire logic output_on_cmd,
    input wire logic status_clear,
    // Outputs
    input wire logic [7:0] overcurrent_response_setting,
    input wire logic output_enable,
    input wire logic current_limit_active,
    input wire logic oc_fault_flag,
    input wire logic host_notify,
    input wire logic latched_off
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Setting fields
    wire logic [1:0] act = overcurrent_response_setting[7:6];
    wire logic [2:0] rty = overcurrent_response_setting[5:3];
    wire logic calm = output_enable && !cfg_wr && !other_fault;

    chk_notify_rise: assert property (host_notify |-> $rose(oc_fault_flag))
        else $error("notify without a new flag");
    chk_flag_held: assert property (oc_fault_flag && !status_clear |=> oc_fault_flag)
        else $error("flag dropped without clear");
    chk_flag_set: assert property (oc_detect && output_enable |=> oc_fault_flag)
        else $error("flag not set on fault");
    chk_limit_forever: assert property (act == 2'h0 && calm && output_on_cmd |=> output_enable)
        else $error("limit mode shut down");
    chk_imm_off: assert property (act == 2'h3 && calm && oc_detect |=> !output_enable)
        else $error("no immediate shutdown");
    chk_floor_off: assert property (act == 2'h1 && calm && current_limit_active && oc_detect && below_lv_floor
        |=> !output_enable) else $error("no shutdown below floor");
    chk_latch_hold: assert property (latched_off && output_on_cmd |=> latched_off && !output_enable)
        else $error("latch left without off-on");
    chk_no_retry: assert property (act == 2'h3 && rty == 3'h0 && calm && output_on_cmd && oc_detect
        |-> ##[1:4] latched_off) else $error("retry zero not latched");
endmodule

/* File: dv/ocfrs_host_model.sv */
/*
 Host model: writes the response setting and clears status.
 Assumes the bench calls its tasks at falling edges.
*/
`timescale 1ns/1ns
module ocfrs_host_model (
    // Clock
    input wire logic sys_clk,
    // Register and status strobes
    output logic cfg_wr,
    output logic [7:0] cfg_wdata,
    output logic status_clear
);
    // Idle values at time zero
    initial begin
        cfg_wr = 1'b0;
        cfg_wdata = 8'h00;
        status_clear = 1'b0;
    end
    // One-cycle write; idle data inverted so stale use shows
    task automatic write(input logic [7:0] d);
        @(negedge sys_clk);
        cfg_wr = 1'b1;
        cfg_wdata = d;
        @(negedge sys_clk);
        cfg_wr = 1'b0;
        cfg_wdata = ~d;
    endtask
    // One-cycle status clear
    task automatic clear();
        @(negedge sys_clk);
        status_clear = 1'b1;
        @(negedge sys_clk);
        status_clear = 1'b0;
    endtask
endmodule

/* File: dv/ocfrs_sequencer_tb.sv */
/*
 Bench for the fault sequencer: host model, reference counts, checker.
 Assumes rtl/ on the include path; unit shortened to 4 cycles.
*/
`timescale 1ns/1ns
module ocfrs_sequencer_tb;
    localparam int UNIT = 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic oc_detect = 1'b0;
    logic below_lv_floor = 1'b0;
    logic other_fault = 1'b0;
    logic output_on_cmd = 1'b1;
    logic cfg_wr, status_clear, output_enable, current_limit_active, oc_fault_flag, host_notify, latched_off;
    logic [7:0] cfg_wdata, setting;
    logic [2:0] retries_left, d;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_rise, n_note, gap, exp_gap, arm, since_rise;

    // Clock, 100 ns period
    always #50 sys_clk = ~sys_clk;

    ocfrs_host_model HOST (.sys_clk(sys_clk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .status_clear(status_clear));
    ocfrs_sequencer #(.UNIT_CYCLES(UNIT), .RESTART_CYCLES(16)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .overcurrent_response_setting(setting), .oc_detect(oc_detect),
        .below_lv_floor(below_lv_floor), .other_fault(other_fault), .output_on_cmd(output_on_cmd),
        .status_clear(status_clear), .output_enable(output_enable), .current_limit_active(current_limit_active),
        .oc_fault_flag(oc_fault_flag), .host_notify(host_notify), .latched_off(latched_off),
        .retries_left(retries_left));

    // Compare tasks and verdict
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpb(input logic got, input logic exp);
        cmp({7'h00, got}, {7'h00, exp});
    endtask
    task automatic results();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Off then on again clears a latched shutdown, then status clear
    task automatic recycle();
        oc_detect = 1'b0;
        below_lv_floor = 1'b0;
        output_on_cmd = 1'b0;
        wait_n(3);
        output_on_cmd = 1'b1;
        wait_n(3);
        HOST.clear();
    endtask

    // Monitor at falling edges, where outputs are settled: notifications, restarts;
    // first restart timed from shutdown, later ones from the previous attempt's start
    always @(negedge sys_clk) begin
        if (host_notify === 1'b1) n_note++;
        since_rise++;
        if (output_enable !== 1'b1) gap++;
        else begin
            if (arm && gap > 0) begin
                cmp(8'((n_rise == 0) ? gap : since_rise), 8'(exp_gap));
                n_rise++;
                since_rise = 0;
            end
            gap = 0;
        end
    end

    // Immediate shutdown with a retry budget; fault never goes away
    task automatic run_imm(input logic [2:0] r);
        HOST.write({2'h3, r, d});
        exp_gap = d * UNIT + 1;
        n_rise = 0;
        n_note = 0;
        arm = 1;
        oc_detect = 1'b1;
        wait_n(400);
        arm = 0;
        cmp(8'(n_note), 8'h01);
        cmpb(latched_off, r != 3'h7);
        if (r == 3'h7) begin
            cmpb(n_rise > 8, 1'b1);
            other_fault = 1'b1;
            wait_n(40);
            cmpb(output_enable, 1'b0);
            other_fault = 1'b0;
        end else cmp(8'(n_rise), {5'h00, r});
        recycle();
    endtask

    // Delayed shutdown; fault held past the delay or removed before it
    task automatic run_dly(input logic hold);
        HOST.write({2'h2, 3'h0, d});
        oc_detect = 1'b1;
        wait_n(d * UNIT - 1);
        cmpb(output_enable, 1'b1);
        if (!hold) oc_detect = 1'b0;
        wait_n(6);
        cmpb(output_enable, !hold);
        cmpb(latched_off, hold);
        recycle();
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'h415f));
        wait_n(20);
        rst_n = 1'b1;
        wait_n(2);
        cmp(setting, 8'hc0);
        cmpb(oc_fault_flag, 1'b0);
        cmpb(output_enable, 1'b1);
        d = 3'($urandom);
        HOST.write({d, 5'h15});
        cmp(setting, {d, 5'h15});
        foreach (d[i]) begin
            d = 3'($urandom_range(7, 1));
            run_imm(3'(i * 3));
            run_dly(1'(i));
        end
        d = 3'($urandom_range(7, 1));
        run_imm(3'h1);
        run_imm(3'h7);
        // Fault clears during the wait: restart succeeds, budget reloads
        HOST.write(8'hd9);
        oc_detect = 1'b1;
        wait_n(1);
        oc_detect = 1'b0;
        wait_n(2);
        cmp({5'h00, retries_left}, 8'h02);
        wait_n(60);
        cmp({5'h00, retries_left}, 8'h03);
        cmpb(output_enable, 1'b1);
        cmpb(oc_fault_flag, 1'b1);
        HOST.clear();
        cmpb(oc_fault_flag, 1'b0);
        // Plain limiting never shuts down
        HOST.write(8'h09);
        oc_detect = 1'b1;
        wait_n(200);
        cmpb(output_enable, 1'b1);
        cmpb(current_limit_active, 1'b1);
        // Limiting with a floor, then the voltage drops below it
        HOST.write(8'h41);
        wait_n(10);
        cmpb(output_enable, 1'b1);
        below_lv_floor = 1'b1;
        wait_n(3);
        cmpb(latched_off, 1'b1);
        recycle();
        results();
    end

    // Watchdog against a hang
    initial begin
        #2000000;
        n_mismatch++;
        results();
    end
endmodule

bind ocfrs_sequencer ocfrs_sequencer_chk CHK (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
    .oc_detect(oc_detect), .below_lv_floor(below_lv_floor), .other_fault(other_fault),
    .output_on_cmd(output_on_cmd), .status_clear(status_clear),
    .overcurrent_response_setting(overcurrent_response_setting), .output_enable(output_enable),
    .current_limit_active(current_limit_active), .oc_fault_flag(oc_fault_flag),
    .host_notify(host_notify), .latched_off(latched_off));
